// file: rtl/cxt_cost_rom.sv
// Constant lookup of base clocks and bus reads/writes per operation.
// Assumes op is stable while the caller samples the result.
`timescale 1ns/1ps
`default_nettype none
`include "cxt_regs.svh"

module cxt_cost_rom (
    // Operation select
    input  wire logic [`CXT_OP_W-1:0] op,
    // Cost
    output var  cxt_pkg::cxt_cost_t   cost,
    output var  logic                 known
);

    function automatic cxt_pkg::cxt_cost_t mk(input logic [7:0] c,
        input logic [4:0] r, input logic [4:0] w, input logic ea,
        input logic ack);
        cxt_pkg::cxt_cost_t t;
        t.clocks    = c;
        t.reads     = r;
        t.writes    = w;
        t.add_ea    = ea;
        t.ack_cycle = ack;
        return t;
    endfunction

    always_comb begin
        known = 1'b1;
        unique case (op)
            `CXT_OP_STORE_STATUS:   cost = mk(8'd8, 5'd1, 5'd1, 1'b1, 1'b0);
            `CXT_OP_STORE_FLAGS:    cost = mk(8'd8, 5'd1, 5'd1, 1'b1, 1'b0);
            `CXT_OP_RFE_LONG_RR:    cost = mk(8'd112, 5'd27, 5'd0, 1'b0, 1'b0);
            `CXT_OP_RFE_LONG_RW:    cost = mk(8'd112, 5'd26, 5'd1, 1'b0, 1'b0);
            `CXT_OP_RFE_LONG_NR:    cost = mk(8'd110, 5'd26, 5'd0, 1'b0, 1'b0);
            `CXT_OP_RFE_SHORT:      cost = mk(8'd24, 5'd6, 5'd0, 1'b0, 1'b0);
            `CXT_OP_STOP:           cost = mk(8'd4, 5'd0, 5'd0, 1'b0, 1'b0);
            `CXT_OP_RESET_INSN:     cost = mk(8'd130, 5'd1, 5'd0, 1'b0, 1'b0);
            `CXT_OP_MCR_TO_CTRL:    cost = mk(8'd10, 5'd2, 5'd0, 1'b0, 1'b0);
            `CXT_OP_MCR_FROM_CTRL:  cost = mk(8'd12, 5'd2, 5'd0, 1'b0, 1'b0);
            `CXT_OP_MPD_W_TO_MEM:   cost = mk(8'd16, 5'd2, 5'd2, 1'b0, 1'b0);
            `CXT_OP_MPD_L_TO_MEM:   cost = mk(8'd24, 5'd2, 5'd4, 1'b0, 1'b0);
            `CXT_OP_MPD_W_FROM_MEM: cost = mk(8'd16, 5'd4, 5'd0, 1'b0, 1'b0);
            `CXT_OP_MPD_L_FROM_MEM: cost = mk(8'd24, 5'd6, 5'd0, 1'b0, 1'b0);
            `CXT_OP_MAS_BW_TO_MEM:  cost = mk(8'd16, 5'd2, 5'd1, 1'b1, 1'b0);
            `CXT_OP_MAS_L_TO_MEM:   cost = mk(8'd20, 5'd2, 5'd2, 1'b1, 1'b0);
            `CXT_OP_MAS_BW_FROM:    cost = mk(8'd16, 5'd3, 5'd0, 1'b1, 1'b0);
            `CXT_OP_MAS_L_FROM:     cost = mk(8'd20, 5'd4, 5'd0, 1'b1, 1'b0);
            `CXT_OP_NOP:            cost = mk(8'd4, 5'd1, 5'd0, 1'b0, 1'b0);
            `CXT_OP_EX_ADDR_ERR:    cost = mk(8'd126, 5'd4, 5'd26, 1'b0, 1'b0);
            `CXT_OP_EX_BUS_ERR:     cost = mk(8'd126, 5'd4, 5'd26, 1'b0, 1'b0);
            `CXT_OP_EX_BREAKPOINT:  cost = mk(8'd42, 5'd5, 5'd4, 1'b0, 1'b1);
            `CXT_OP_EX_INTERRUPT:   cost = mk(8'd46, 5'd5, 5'd4, 1'b0, 1'b1);
            `CXT_OP_EX_RESET:       cost = mk(8'd40, 5'd6, 5'd0, 1'b0, 1'b0);
            `CXT_OP_EX_ILLEGAL:     cost = mk(8'd38, 5'd4, 5'd4, 1'b0, 1'b0);
            `CXT_OP_EX_TRAP:        cost = mk(8'd38, 5'd4, 5'd4, 1'b0, 1'b0);
            `CXT_OP_EX_DIV_ZERO:    cost = mk(8'd42, 5'd5, 5'd4, 1'b0, 1'b0);
            `CXT_OP_EX_CHK:         cost = mk(8'd44, 5'd5, 5'd4, 1'b1, 1'b0);
            `CXT_OP_EX_BAD_FORMAT:  cost = mk(8'd50, 5'd7, 5'd4, 1'b0, 1'b0);
            `CXT_OP_EX_BAD_REV:     cost = mk(8'd70, 5'd12, 5'd4, 1'b0, 1'b0);
            `CXT_OP_EX_TRAPV:       cost = mk(8'd40, 5'd5, 5'd4, 1'b0, 1'b0);
            `CXT_OP_EX_BAD_CTRL:    cost = mk(8'd46, 5'd5, 5'd4, 1'b0, 1'b0);
            `CXT_OP_MP_COMPARE:     cost = mk(8'd12, 5'd3, 5'd0, 1'b0, 1'b0);
            `CXT_OP_MP_OTHER:       cost = mk(8'd18, 5'd3, 5'd1, 1'b0, 1'b0);
            default: begin
                cost  = mk(8'd4, 5'd1, 5'd0, 1'b0, 1'b0);
                known = 1'b0;
            end
        endcase
    end

endmodule
`default_nettype wire

// file: rtl/cxt_pkg.sv
// Types for the cycle-timing model.
// Assumes cxt_regs.svh is compiled alongside.
`include "cxt_regs.svh"

package cxt_pkg;
    typedef logic [`CXT_CNT_W-1:0] cxt_cnt_t;
    typedef logic [`CXT_BUS_W-1:0] cxt_bus_t;

    typedef struct packed {
        cxt_cnt_t clocks;
        cxt_bus_t reads;
        cxt_bus_t writes;
        logic     add_ea;
        logic     ack_cycle;
    } cxt_cost_t;

    typedef enum logic [1:0] {
        CXT_IDLE  = 2'b00,
        CXT_COUNT = 2'b01,
        CXT_DONE  = 2'b11
    } cxt_state_t;
endpackage

// file: rtl/cxt_regs.svh
// Timing constants for the exception and miscellaneous cycle-timing model.
// Assumes inclusion by bare name from the rtl directory.
`ifndef CXT_REGS_SVH
`define CXT_REGS_SVH

// ----------------------------------------------------------------
// Clock
// ----------------------------------------------------------------
`define CXT_CLK_PERIOD_NS     4

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define CXT_OP_W              6
`define CXT_CNT_W             8
`define CXT_BUS_W             5
`define CXT_EA_W              8

// ----------------------------------------------------------------
// Assumed acknowledge cycle length (processor clocks)
// ----------------------------------------------------------------
`define CXT_ACK_CLOCKS        8'h04

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define CXT_OP_STORE_STATUS   6'h00
`define CXT_OP_STORE_FLAGS    6'h01
`define CXT_OP_RFE_LONG_RR    6'h02
`define CXT_OP_RFE_LONG_RW    6'h03
`define CXT_OP_RFE_LONG_NR    6'h04
`define CXT_OP_RFE_SHORT      6'h05
`define CXT_OP_STOP           6'h06
`define CXT_OP_RESET_INSN     6'h07
`define CXT_OP_MCR_TO_CTRL    6'h08
`define CXT_OP_MCR_FROM_CTRL  6'h09
`define CXT_OP_MPD_W_TO_MEM   6'h0a
`define CXT_OP_MPD_L_TO_MEM   6'h0b
`define CXT_OP_MPD_W_FROM_MEM 6'h0c
`define CXT_OP_MPD_L_FROM_MEM 6'h0d
`define CXT_OP_MAS_BW_TO_MEM  6'h0e
`define CXT_OP_MAS_L_TO_MEM   6'h0f
`define CXT_OP_MAS_BW_FROM    6'h10
`define CXT_OP_MAS_L_FROM     6'h11
`define CXT_OP_NOP            6'h12
`define CXT_OP_EX_ADDR_ERR    6'h20
`define CXT_OP_EX_BUS_ERR     6'h21
`define CXT_OP_EX_BREAKPOINT  6'h22
`define CXT_OP_EX_INTERRUPT   6'h23
`define CXT_OP_EX_RESET       6'h24
`define CXT_OP_EX_ILLEGAL     6'h25
`define CXT_OP_EX_TRAP        6'h26
`define CXT_OP_EX_DIV_ZERO    6'h27
`define CXT_OP_EX_CHK         6'h28
`define CXT_OP_EX_BAD_FORMAT  6'h29
`define CXT_OP_EX_BAD_REV     6'h2a
`define CXT_OP_EX_TRAPV       6'h2b
`define CXT_OP_EX_BAD_CTRL    6'h2c
`define CXT_OP_MP_COMPARE     6'h30
`define CXT_OP_MP_OTHER       6'h31

// ----------------------------------------------------------------
// Addressing modes of multi-precision memory forms
// ----------------------------------------------------------------
`define CXT_MODE_NONE         2'h0
`define CXT_MODE_POSTINC      2'h1
`define CXT_MODE_PREDEC       2'h2

`endif

// file: rtl/cxt_timing.sv
// Cycle-count timing model for miscellaneous instructions and exceptions.
// Assumes start pulses come from a sequencer on sys_clk; one op at a time.
//
// Summary of operation
// - Address-calc cost added where op requires it
// - Status/flags store: 8 clocks, 1 read, 1 write
// - Each timing is clocks plus reads and writes
// - Stop: 4 clocks, no bus cycles
// - Reset instruction: 130 clocks, one read
// - Control move 10/12 clocks, two reads
// - Exception cost covers stacking, vector, prefetch
// - Address/bus error: 126 clocks, 4 reads, 26 writes
// - Acknowledge cycle assumed four clocks, longer ones stretched
// - Reset processing 40 clocks after reset, suspend negate
// - Compare uses postincrement; others use predecrement
`timescale 1ns/1ps
`default_nettype none
`include "cxt_regs.svh"

module cxt_timing (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  srst,

    // Processor reset and suspend inputs, high while asserted
    input  wire logic                  cpu_reset_in,
    input  wire logic                  cpu_suspend_in,

    // Operation request
    input  wire logic                  op_start,
    input  wire logic [`CXT_OP_W-1:0]  op_code,
    input  wire logic [`CXT_EA_W-1:0]  ea_clocks,
    input  wire logic [`CXT_BUS_W-1:0] ea_reads,
    input  wire logic [`CXT_BUS_W-1:0] ea_writes,

    // Acknowledge cycle length reported by responder
    input  wire logic [`CXT_CNT_W-1:0] ack_clocks,

    // Status
    output logic                       busy,
    output logic                       done,
    output logic                       bad_op,
    output logic [1:0]                 addr_mode,

    // Bus cycle issue, one-cycle pulses
    output logic                       bus_read,
    output logic                       bus_write,

    // Totals of the current operation
    output logic [9:0]                 total_clocks,
    output logic [5:0]                 total_reads,
    output logic [5:0]                 total_writes
);

    // ----------------------------------------------------------------
    // Cost lookup
    // ----------------------------------------------------------------
    cxt_pkg::cxt_cost_t cost;
    logic               known;
    logic [`CXT_OP_W-1:0] op_sel;

    cxt_cost_rom u_rom (
        .op    (op_sel),
        .cost  (cost),
        .known (known)
    );

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    cxt_pkg::cxt_state_t state_q;
    cxt_pkg::cxt_state_t state_d;

    // Remaining clocks and bus cycles of the running op
    logic [9:0]          clk_left_q;
    logic [5:0]          rd_left_q;
    logic [5:0]          wr_left_q;
    // Set while reset processing is owed
    logic                rst_seen_q;

    // Output flops
    logic                busy_q;
    logic                done_q;
    logic                bad_q;
    logic [1:0]          mode_q;
    logic                rd_q;
    logic                wr_q;
    logic [9:0]          tclk_q;
    logic [5:0]          trd_q;
    logic [5:0]          twr_q;

    // Reset processing starts on the first negated sample of both inputs
    wire        rst_held  = cpu_reset_in | cpu_suspend_in;
    wire        rst_go    = rst_seen_q & ~rst_held & (state_q == cxt_pkg::CXT_IDLE);
    assign op_sel = rst_go ? `CXT_OP_EX_RESET : op_code;
    // A request waits out reset processing and any running count
    wire        req_ok    = op_start & ~rst_seen_q & ~rst_held;
    wire        room      = (state_q != cxt_pkg::CXT_COUNT);
    wire        take      = rst_go | (req_ok & room);

    // Slow acknowledge stretches the total by the excess
    wire [7:0]  ack_extra = (cost.ack_cycle && ack_clocks > `CXT_ACK_CLOCKS) ?
                            ack_clocks - `CXT_ACK_CLOCKS : 8'h00;
    wire        use_ea    = cost.add_ea & ~rst_go;

    wire [9:0]  new_clk   = {2'b00, cost.clocks} + {2'b00, ack_extra} +
                            (use_ea ? {2'b00, ea_clocks} : 10'h000);
    wire [5:0]  new_rd    = {1'b0, cost.reads} +
                            (use_ea ? {1'b0, ea_reads} : 6'h00);
    wire [5:0]  new_wr    = {1'b0, cost.writes} +
                            (use_ea ? {1'b0, ea_writes} : 6'h00);

    // Only the multi-precision pair names an addressing mode
    wire [1:0]  new_mode  = (op_sel == `CXT_OP_MP_COMPARE) ? `CXT_MODE_POSTINC :
                            (op_sel == `CXT_OP_MP_OTHER) ? `CXT_MODE_PREDEC :
                            `CXT_MODE_NONE;

    // An op of N clocks taken at edge 0 is busy for cycles 1..N and
    // pulses done in cycle N+1; a held request is taken in that done
    // cycle, so back-to-back ops start N+1 clocks apart.
    // Limitation: reset or suspend does not cut a running op short.

    // Bus cycles go out one per two clocks; reads first, then writes,
    // so they always fit inside the total (clocks >= 2*(r+w) by table).
    wire        slot      = (state_q == cxt_pkg::CXT_COUNT) & clk_left_q[0];
    wire        issue_rd  = slot & (rd_left_q != 6'h00);
    wire        issue_wr  = slot & (rd_left_q == 6'h00) & (wr_left_q != 6'h00);
    // Final counting cycle; done follows one clock later
    wire        last      = (state_q == cxt_pkg::CXT_COUNT) & (clk_left_q == 10'h001);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            cxt_pkg::CXT_IDLE:  if (take) state_d = cxt_pkg::CXT_COUNT;
            cxt_pkg::CXT_COUNT: if (last) state_d = cxt_pkg::CXT_DONE;
            cxt_pkg::CXT_DONE:  state_d = take ? cxt_pkg::CXT_COUNT :
                                                 cxt_pkg::CXT_IDLE;
            default:            state_d = cxt_pkg::CXT_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q <= cxt_pkg::CXT_IDLE;
            rst_seen_q <= 1'b1;
        end else begin
            state_q <= state_d;
            // Held inputs re-arm reset processing
            if (rst_held)
                rst_seen_q <= 1'b1;
            else if (rst_go)
                rst_seen_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            clk_left_q <= 10'h000;
            rd_left_q  <= 6'h00;
            wr_left_q  <= 6'h00;
        end else if (take) begin
            clk_left_q <= new_clk;
            rd_left_q  <= new_rd;
            wr_left_q  <= new_wr;
        end else if (state_q == cxt_pkg::CXT_COUNT) begin
            clk_left_q <= clk_left_q - 10'h001;
            rd_left_q  <= rd_left_q - {5'h00, issue_rd};
            wr_left_q  <= wr_left_q - {5'h00, issue_wr};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            rd_q   <= 1'b0;
            wr_q   <= 1'b0;
        end else begin
            // From next state, so busy rises with the first count
            busy_q <= (state_d == cxt_pkg::CXT_COUNT);
            done_q <= last;
            rd_q   <= issue_rd;
            wr_q   <= issue_wr;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            bad_q  <= 1'b0;
            mode_q <= `CXT_MODE_NONE;
            tclk_q <= 10'h000;
            trd_q  <= 6'h00;
            twr_q  <= 6'h00;
        end else if (take) begin
            // Unknown codes still run, as a one-read filler op
            bad_q  <= ~known;
            mode_q <= new_mode;
            tclk_q <= new_clk;
            trd_q  <= new_rd;
            twr_q  <= new_wr;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Totals, mode and bad_op hold until the next take
    assign busy         = busy_q;
    assign done         = done_q;
    assign bad_op       = bad_q;
    assign addr_mode    = mode_q;
    assign bus_read     = rd_q;
    assign bus_write    = wr_q;
    assign total_clocks = tclk_q;
    assign total_reads  = trd_q;
    assign total_writes = twr_q;

endmodule
`default_nettype wire

// file: test/cxt_ack_responder.sv
// Acknowledge responder: reports how long its acknowledge cycle takes.
// Assumes the bench picks the mode per request.
`timescale 1ns/1ps
`default_nettype none
`include "cxt_regs.svh"

module cxt_ack_responder (
    // Mode: 0 prompt, 1 slow by stretch, 2 early
    input  wire logic [1:0] mode,
    input  wire logic [7:0] stretch,
    // Reported acknowledge length
    output var  logic [7:0] ack_clocks
);
    always_comb begin
        case (mode)
            2'h1: ack_clocks = `CXT_ACK_CLOCKS + stretch;
            2'h2: ack_clocks = 8'h02;
            default: ack_clocks = `CXT_ACK_CLOCKS;
        endcase
    end
endmodule
`default_nettype wire

// file: test/cxt_timing_bench.sv
// Self-checking bench for the cycle-timing model, every op code back to back.
// Assumes the monitor is bound by its own file.
`timescale 1ns/1ps
`default_nettype none
`include "cxt_regs.svh"

module cxt_timing_bench;
    typedef struct packed {
        logic [9:0] c;
        logic [5:0] r;
        logic [5:0] w;
        logic [1:0] m;
        logic       b;
        logic       t;
    } cxt_note_t;

    logic       sys_clk, srst, cpu_reset_in, cpu_suspend_in, op_start;
    logic [5:0] op_code;
    logic [7:0] ea_clocks, ack_clocks, stretch;
    logic [4:0] ea_reads, ea_writes;
    logic [1:0] mode, addr_mode, k;
    logic       busy, done, bad_op, bus_read, bus_write;
    logic [9:0] total_clocks;
    logic [5:0] total_reads, total_writes;
    int         mismatches, check_count, seed, bc, rc, wc, op;
    cxt_note_t  notes[$];
    cxt_note_t  n;

    cxt_timing cxt_timing_i (.sys_clk, .srst, .cpu_reset_in, .cpu_suspend_in,
        .op_start, .op_code, .ea_clocks, .ea_reads, .ea_writes, .ack_clocks,
        .busy, .done, .bad_op, .addr_mode, .bus_read, .bus_write,
        .total_clocks, .total_reads, .total_writes);
    cxt_ack_responder cxt_ack_responder_i (.mode, .stretch, .ack_clocks);

    // ----------------------------------------------------------------
    // Expected cost, address-calc share and acknowledge stretch included
    // ----------------------------------------------------------------
    function automatic cxt_note_t cost(logic [5:0] o, logic [1:0] q,
                                       logic [7:0] a);
        cxt_note_t  e;
        logic [21:0] v;
        e = '0;
        e.t = 1'b1;
        case (o)
            `CXT_OP_STORE_STATUS, `CXT_OP_STORE_FLAGS: v = {10'h008, 6'h01, 6'h01};
            `CXT_OP_RFE_LONG_RR: v = {10'h070, 6'h1b, 6'h00};
            `CXT_OP_RFE_LONG_RW: v = {10'h070, 6'h1a, 6'h01};
            `CXT_OP_RFE_LONG_NR: v = {10'h06e, 6'h1a, 6'h00};
            `CXT_OP_RFE_SHORT, `CXT_OP_MPD_L_FROM_MEM: v = {10'h018, 6'h06, 6'h00};
            `CXT_OP_STOP: v = {10'h004, 6'h00, 6'h00};
            `CXT_OP_RESET_INSN: v = {10'h082, 6'h01, 6'h00};
            `CXT_OP_MCR_TO_CTRL: v = {10'h00a, 6'h02, 6'h00};
            `CXT_OP_MCR_FROM_CTRL: v = {10'h00c, 6'h02, 6'h00};
            `CXT_OP_MPD_W_TO_MEM: v = {10'h010, 6'h02, 6'h02};
            `CXT_OP_MPD_L_TO_MEM: v = {10'h018, 6'h02, 6'h04};
            `CXT_OP_MPD_W_FROM_MEM: v = {10'h010, 6'h04, 6'h00};
            `CXT_OP_MAS_BW_TO_MEM: v = {10'h010, 6'h02, 6'h01};
            `CXT_OP_MAS_L_TO_MEM: v = {10'h014, 6'h02, 6'h02};
            `CXT_OP_MAS_BW_FROM: v = {10'h010, 6'h03, 6'h00};
            `CXT_OP_MAS_L_FROM: v = {10'h014, 6'h04, 6'h00};
            `CXT_OP_NOP: v = {10'h004, 6'h01, 6'h00};
            `CXT_OP_EX_ADDR_ERR, `CXT_OP_EX_BUS_ERR: v = {10'h07e, 6'h04, 6'h1a};
            `CXT_OP_EX_BREAKPOINT, `CXT_OP_EX_DIV_ZERO: v = {10'h02a, 6'h05, 6'h04};
            `CXT_OP_EX_INTERRUPT, `CXT_OP_EX_BAD_CTRL: v = {10'h02e, 6'h05, 6'h04};
            `CXT_OP_EX_RESET: v = {10'h028, 6'h06, 6'h00};
            `CXT_OP_EX_ILLEGAL, `CXT_OP_EX_TRAP: v = {10'h026, 6'h04, 6'h04};
            `CXT_OP_EX_CHK: v = {10'h02c, 6'h05, 6'h04};
            `CXT_OP_EX_BAD_FORMAT: v = {10'h032, 6'h07, 6'h04};
            `CXT_OP_EX_BAD_REV: v = {10'h046, 6'h0c, 6'h04};
            `CXT_OP_EX_TRAPV: v = {10'h028, 6'h05, 6'h04};
            `CXT_OP_MP_COMPARE: v = {10'h00c, 6'h03, 6'h00};
            `CXT_OP_MP_OTHER: v = {10'h012, 6'h03, 6'h01};
            default: begin
                v = {10'h004, 6'h01, 6'h00};
                e.b = 1'b1;
            end
        endcase
        {e.c, e.r, e.w} = v;
        if (o inside {`CXT_OP_STORE_STATUS, `CXT_OP_STORE_FLAGS, `CXT_OP_EX_CHK,
                      `CXT_OP_MAS_BW_TO_MEM, `CXT_OP_MAS_L_TO_MEM,
                      `CXT_OP_MAS_BW_FROM, `CXT_OP_MAS_L_FROM}) begin
            e.c = e.c + {6'h00, q, 2'h0};
            e.r = e.r + {4'h0, q};
            e.w = e.w + {4'h0, q};
        end
        if (o inside {`CXT_OP_EX_BREAKPOINT, `CXT_OP_EX_INTERRUPT} && a > 8'h04)
            e.c = e.c + 10'(a) - 10'h004;
        e.m = o == `CXT_OP_MP_COMPARE ? 2'h1 : o == `CXT_OP_MP_OTHER ? 2'h2 : 2'h0;
        return e;
    endfunction

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic results();
        if (mismatches == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wait_for(input bit for_done);
        int i;
        for (i = 0; i < 400; i++) begin
            @(negedge sys_clk);
            if (for_done ? done === 1'b1 : busy === 1'b0)
                break;
        end
        if (i == 400) begin
            mismatches++;
            results();
        end
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Watcher: counts busy cycles and bus pulses, settles them on done
    initial begin
        forever begin
            @(negedge sys_clk);
            bc += int'(busy === 1'b1);
            rc += int'(bus_read === 1'b1);
            wc += int'(bus_write === 1'b1);
            if (srst !== 1'b0) begin
                bc = 0;
                rc = 0;
                wc = 0;
            end else if (done === 1'b1) begin
                n = notes.size() > 0 ? notes.pop_front() : '1;
                check("clocks", 16'(bc), 16'(n.c));
                check("reads", 16'(rc), 16'(n.r));
                check("writes", 16'(wc), 16'(n.w));
                if (n.t) begin
                    check("total clocks", 16'(total_clocks), 16'(n.c));
                    check("total bus", {total_reads, total_writes}, {n.r, n.w});
                    check("addr mode", 16'(addr_mode), 16'(n.m));
                    check("bad op", 16'(bad_op), 16'(n.b));
                end
                bc = 0;
                rc = 0;
                wc = 0;
            end
        end
    end

    initial begin
        seed = 32'h554b6304;
        {srst, cpu_reset_in, cpu_suspend_in, op_start} = 4'h e;
        {op_code, ea_clocks, ea_reads, ea_writes, mode, stretch} = '0;
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (5) @(posedge sys_clk);
        // Request while still suspended must be ignored
        cpu_reset_in <= 1'b0;
        op_start <= 1'b1;
        op_code <= `CXT_OP_STOP;
        repeat (5) @(posedge sys_clk);
        cpu_suspend_in <= 1'b0;
        op_start <= 1'b0;
        notes.push_back({10'h028, 6'h06, 6'h00, 4'h0});
        wait_for(1'b1);
        // Request held high: each op after the first is taken in its predecessor's done cycle
        for (op = 0; op < 64; op++) begin
            @(posedge sys_clk);
            k = 2'($random(seed));
            mode <= 2'($unsigned($random(seed)) % 3);
            stretch <= 8'($random(seed)) & 8'h1f;
            op_start <= 1'b1;
            op_code <= 6'(op);
            ea_clocks <= {4'h0, k, 2'h0};
            ea_reads <= {3'h0, k};
            ea_writes <= {3'h0, k};
            wait_for(1'b0);
            notes.push_back(cost(6'(op), k, mode == 2'h1 ? 8'h04 + stretch :
                                 mode == 2'h2 ? 8'h02 : 8'h04));
        end
        @(posedge sys_clk);
        op_start <= 1'b0;
        wait_for(1'b1);
        // Processor reset after the run has finished reruns reset processing
        @(posedge sys_clk);
        cpu_reset_in <= 1'b1;
        repeat (3) @(posedge sys_clk);
        cpu_reset_in <= 1'b0;
        notes.push_back({10'h028, 6'h06, 6'h00, 4'h0});
        wait_for(1'b1);
        @(posedge sys_clk);
        check("pending notes", 16'(notes.size()), 16'h0000);
        results();
    end
endmodule
`default_nettype wire

// file: test/cxt_timing_monitor.sv
// Concurrent checks on the ports of the cycle-timing model.
// Assumes one clock domain and bind onto every cxt_timing instance.
`timescale 1ns/1ps
`default_nettype none
`include "cxt_regs.svh"

module cxt_timing_monitor (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       srst,
    // Stimulus seen by the model
    input wire logic       cpu_reset_in,
    input wire logic       cpu_suspend_in,
    input wire logic       op_start,
    input wire logic [5:0] op_code,
    input wire logic [7:0] ea_clocks,
    input wire logic [4:0] ea_reads,
    input wire logic [4:0] ea_writes,
    input wire logic [7:0] ack_clocks,
    // Model outputs
    input wire logic       busy,
    input wire logic       done,
    input wire logic       bad_op,
    input wire logic [1:0] addr_mode,
    input wire logic       bus_read,
    input wire logic       bus_write,
    input wire logic [9:0] total_clocks,
    input wire logic [5:0] total_reads,
    input wire logic [5:0] total_writes
);
    logic [9:0] cnt_q;
    logic [5:0] rc_q;
    logic [5:0] wc_q;
    logic       wr_q;
    logic       armed_q;
    // Taken only once the automatic reset processing has finished
    wire logic  take = op_start && !cpu_reset_in && !cpu_suspend_in
                       && !busy && armed_q;

    always_ff @(posedge sys_clk) begin
        if (srst || done) begin
            cnt_q <= 10'h000;
            rc_q  <= 6'h00;
            wc_q  <= 6'h00;
            wr_q  <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 10'(busy);
            rc_q  <= rc_q + 6'(bus_read);
            wc_q  <= wc_q + 6'(bus_write);
            wr_q  <= wr_q || bus_write;
        end
        armed_q <= !srst && (armed_q || done);
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);

    done_pulse_a: assert property (done |=> !done)
        else $error("done held longer than one cycle");
    idle_quiet_a: assert property (!busy && !done |-> !bus_read && !bus_write)
        else $error("bus cycle outside an operation");
    read_order_a: assert property (bus_read |-> !wr_q)
        else $error("read issued after a write");
    take_busy_a: assert property (take |=> busy)
        else $error("accepted request did not raise busy");
    clk_count_a: assert property (done && armed_q |-> cnt_q == total_clocks)
        else $error("operation length differs from its total");
    bus_count_a: assert property (done && armed_q |-> rc_q + 6'(bus_read) == total_reads
        && wc_q + 6'(bus_write) == total_writes)
        else $error("bus cycle count differs from totals");
    reset_proc_a: assert property (done && !armed_q |-> cnt_q == 10'h028
        && rc_q + 6'(bus_read) == 6'h06 && wc_q == 6'h00)
        else $error("reset processing cost wrong");
    stop_cost_a: assert property (take && op_code == `CXT_OP_STOP |=> total_clocks == 10'h004
        && total_reads == 6'h00 && total_writes == 6'h00)
        else $error("stop cost wrong");
    reset_insn_a: assert property (take && op_code == `CXT_OP_RESET_INSN |=>
        total_clocks == 10'h082 && total_reads == 6'h01)
        else $error("reset instruction cost wrong");
    bus_err_a: assert property (take && op_code inside {`CXT_OP_EX_ADDR_ERR,
        `CXT_OP_EX_BUS_ERR} |=> total_clocks == 10'h07e && total_writes == 6'h1a)
        else $error("bus or address error cost wrong");
    ack_len_a: assert property (take && op_code == `CXT_OP_EX_INTERRUPT |=> total_clocks ==
        ($past(ack_clocks) > 8'h04 ? 10'($past(ack_clocks)) + 10'h02a : 10'h02e))
        else $error("interrupt cost ignores acknowledge length");
    mode_sel_a: assert property (take && op_code inside {`CXT_OP_MP_COMPARE, `CXT_OP_MP_OTHER}
        |=> addr_mode == ($past(op_code) == `CXT_OP_MP_COMPARE ? 2'h1 : 2'h2))
        else $error("multi-precision addressing mode wrong");

    cover property (take && op_code == `CXT_OP_STOP);
    cover property (done && op_start && armed_q);
    cover property (take && op_code == `CXT_OP_EX_BREAKPOINT && ack_clocks > 8'h04);
endmodule

bind cxt_timing cxt_timing_monitor cxt_timing_monitor_i (.sys_clk, .srst,
    .cpu_reset_in, .cpu_suspend_in, .op_start, .op_code, .ea_clocks, .ea_reads,
    .ea_writes, .ack_clocks, .busy, .done, .bad_op, .addr_mode, .bus_read,
    .bus_write, .total_clocks, .total_reads, .total_writes);
`default_nettype wire
